// >>> core/ppe_engine.sv
// Purpose: parallel port engine, host requests to interlocked strobe cycles
// Assumes: control bits come from a register on sys_clk, pins are async
// Notes: requests queue in a 16 entry fifo, one cycle runs at a time
`timescale 1ns/1ps

// ----------------------------------------
// request fifo
// ----------------------------------------
module ppe_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // power of two depth keeps pointer wrap free
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("ppe_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage
  logic [AW-1:0] wptr_reg; // write index
  logic [AW-1:0] rptr_reg; // read index
  logic [AW:0] cnt_reg; // fill level
  logic [AW:0] cnt_next;
  logic rdy_reg; // registered not-full

  wire push = in_valid & rdy_reg;
  wire pop = out_ready & (cnt_reg != '0);
  assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rptr_reg];

  // pointers and level
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end
    else if (ce)
    begin
      wptr_reg <= wptr_reg + AW'(push);
      rptr_reg <= rptr_reg + AW'(pop);
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  // storage needs no reset, level guards it
  always_ff @(posedge sys_clk)
  begin
    if (ce && push)
    begin
      mem_reg[wptr_reg] <= in_data;
    end
  end
endmodule : ppe_fifo

// ----------------------------------------
// engine
// ----------------------------------------
module ppe_engine
  import ppe_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // configuration
  input wire ppe_mode_t port_mode,
  input wire logic tmo_clr_mode,
  // control register bits
  input wire logic ctrl_strobe,
  input wire logic ctrl_autofeed,
  input wire logic ctrl_init,
  input wire logic ctrl_select,
  input wire logic port_direction_ctrl,
  input wire logic [7:0] std_data,
  // status register events
  input wire logic status_rd_done,
  input wire logic status_wr_one,
  output logic timeout_flag,
  // host io requests
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [2:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_ready,
  output logic [3:0] lpc_sync,
  output logic lpc_sync_vld,
  output logic [7:0] lpc_rdata,
  // peripheral pins
  input wire logic [7:0] port_bus_in,
  output logic [7:0] port_bus_out,
  output logic port_bus_oe,
  input wire logic peripheral_hold_n,
  output logic data_cycle_strobe_n,
  output logic addr_cycle_strobe_n,
  output logic xfer_out_ind_n,
  output logic bus_dir_out,
  output logic init_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic hold_m_reg; // first stage, read by second only
  logic hold_s_reg; // synchronised hold
  logic [7:0] bus_m_reg;
  logic [7:0] bus_s_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_m_reg <= 1'b1;
      hold_s_reg <= 1'b1;
      bus_m_reg <= REG_RST;
      bus_s_reg <= REG_RST;
    end
    else if (ce)
    begin
      hold_m_reg <= peripheral_hold_n;
      hold_s_reg <= hold_m_reg;
      bus_m_reg <= port_bus_in;
      bus_s_reg <= bus_m_reg;
    end
  end

  // ----------------------------------------
  // request queue
  // ----------------------------------------
  ppe_req_t in_req;
  ppe_req_t fifo_q; // head request
  logic fifo_vld;
  logic fifo_rdy;
  ppe_state_t st_reg;
  ppe_state_t st_next;

  assign in_req = '{wr: io_write, addr: io_addr, data: io_wdata};
  // draining only when idle lets the queue really fill
  assign fifo_rdy = (st_reg == S_IDLE);

  ppe_fifo #(
    .WIDTH($bits(ppe_req_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(io_valid),
    .in_data(in_req),
    .in_ready(io_ready),
    .out_valid(fifo_vld),
    .out_data(fifo_q),
    .out_ready(fifo_rdy)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  ppe_req_t cur_reg; // request in service
  logic [10:0] wd_reg; // watchdog count
  wire pop = fifo_vld & fifo_rdy;
  wire ppe_req_t cur_next = pop ? fifo_q : cur_reg;
  // offsets below the address port belong elsewhere
  wire hit = (fifo_q.addr >= OFS_ADDR) & (port_mode != PM_STD);
  wire v19 = (port_mode == PM_V19);
  // direction bit set turns a write into a read cycle
  wire eff_wr = (cur_next.wr & ~port_direction_ctrl) | ctrl_strobe;
  wire is_addr = (cur_next.addr == OFS_ADDR);
  wire wd_run = (st_reg == S_PRE) | (st_reg == S_SETUP) | (st_reg == S_STRB);
  wire tmo = wd_run & (wd_reg >= TMO_CYC);

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE:
      begin
        // v1.9 waits for hold low first, v1.7 goes straight on
        if (fifo_vld)
          st_next = !hit ? S_SYNC : (v19 ? S_PRE : S_SETUP);
      end
      S_PRE:
      begin
        // strobes and indication untouched until hold drops
        if (tmo)
          st_next = S_SYNC;
        else if (!hold_s_reg)
          st_next = S_SETUP;
      end
      S_SETUP:
      begin
        // bus and direction settle a cycle ahead of strobe
        st_next = tmo ? S_SYNC : S_STRB;
      end
      S_STRB:
      begin
        // hold already low or dropping: finish once high
        if (tmo)
          st_next = S_SYNC;
        else if (hold_s_reg)
          st_next = S_TERM;
      end
      S_TERM:
        st_next = S_SYNC;
      S_SYNC:
        st_next = S_TAR;
      S_TAR:
        st_next = S_IDLE;
      default:
        st_next = S_IDLE;
    endcase
  end

  // state, request and watchdog
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= S_IDLE;
      cur_reg <= '0;
      wd_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      // counts from cycle start, cleared when a new one begins
      wd_reg <= pop ? '0 : (wd_run ? wd_reg + 11'h001 : wd_reg);
    end
  end

  // ----------------------------------------
  // port registers, entry 0 is the address port
  // ----------------------------------------
  logic [7:0] port_reg [NUM_PORT_REGS];
  wire [2:0] cur_idx = cur_reg.addr - OFS_ADDR;
  wire [2:0] q_idx = fifo_q.addr - OFS_ADDR;

  for (genvar k = 0; k < NUM_PORT_REGS; k++)
  begin : g_port
    // written byte on launch, captured byte at strobe release
    wire ld_wr = pop & hit & fifo_q.wr & (q_idx == 3'(k));
    wire ld_rd = (st_reg == S_TERM) & ~eff_wr & (cur_idx == 3'(k));

    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
        port_reg[k] <= REG_RST;
      else if (ce && ld_wr)
        port_reg[k] <= fifo_q.data;
      else if (ce && ld_rd)
        port_reg[k] <= bus_s_reg;
    end
  end

  // ----------------------------------------
  // host answer
  // ----------------------------------------
  logic [3:0] sync_reg;
  logic sync_vld_reg;
  logic [7:0] rdata_reg;
  logic tmo_reg;

  // wait syncs hold the host until the handshake is done
  wire [3:0] sync_next = (st_next == S_SYNC) ? SYNC_READY :
                         (st_next == S_TAR) ? SYNC_TAR : SYNC_LWAIT;

  // set wins over a clear in the same cycle
  wire tmo_clr = tmo_clr_mode ? status_wr_one : status_rd_done;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_reg <= SYNC_TAR;
      sync_vld_reg <= 1'b0;
      rdata_reg <= REG_RST;
      tmo_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync_reg <= sync_next;
      sync_vld_reg <= (st_next != S_IDLE);
      if (tmo)
        rdata_reg <= ABORT_DATA;
      else if (pop && !hit)
        rdata_reg <= UNMAPPED_DATA;
      else if (st_reg == S_TERM)
        rdata_reg <= bus_s_reg;
      if (tmo)
        tmo_reg <= 1'b1;
      else if (tmo_clr)
        tmo_reg <= 1'b0;
    end
  end

  assign lpc_sync = sync_reg;
  assign lpc_sync_vld = sync_vld_reg;
  assign lpc_rdata = rdata_reg;
  assign timeout_flag = tmo_reg;

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic [7:0] pbo_reg;
  logic pboe_reg;
  logic dstb_n_reg;
  logic astb_n_reg;
  logic ind_n_reg;
  logic dir_reg;
  logic init_reg;

  wire cyc_next = (st_next == S_SETUP) | (st_next == S_STRB) | (st_next == S_TERM);
  wire strb_next = (st_next == S_STRB);
  // outside a cycle the pins are plain control outputs
  wire pboe_next = cyc_next ? eff_wr : ~port_direction_ctrl;
  wire [7:0] pbo_next = cyc_next ? cur_next.data : std_data;
  wire dir_next = cyc_next ? ~eff_wr : port_direction_ctrl;
  wire ind_n_next = cyc_next ? ~eff_wr : ~ctrl_strobe;
  wire dstb_n_next = cyc_next ? ~(strb_next & ~is_addr) : ~ctrl_autofeed;
  wire astb_n_next = cyc_next ? ~(strb_next & is_addr) : ~ctrl_select;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pbo_reg <= REG_RST;
      pboe_reg <= 1'b0;
      dstb_n_reg <= 1'b1;
      astb_n_reg <= 1'b1;
      ind_n_reg <= 1'b1;
      dir_reg <= 1'b0;
      init_reg <= 1'b0;
    end
    else if (ce)
    begin
      pbo_reg <= pbo_next;
      pboe_reg <= pboe_next;
      dstb_n_reg <= dstb_n_next;
      astb_n_reg <= astb_n_next;
      ind_n_reg <= ind_n_next;
      dir_reg <= dir_next;
      init_reg <= ctrl_init;
    end
  end

  assign port_bus_out = pbo_reg;
  assign port_bus_oe = pboe_reg;
  assign data_cycle_strobe_n = dstb_n_reg;
  assign addr_cycle_strobe_n = astb_n_reg;
  assign xfer_out_ind_n = ind_n_reg;
  assign bus_dir_out = dir_reg;
  assign init_out = init_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // strobe edges made by idle control bits are not cycle strobes
  wire strb_on = (st_reg == S_STRB);

  sequence s_ready_tar;
    (sync_reg == SYNC_READY) ##1 (sync_reg == SYNC_TAR);
  endsequence

  property p_tmo;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    tmo |=> (st_reg == S_SYNC) && tmo_reg && (rdata_reg == ABORT_DATA);
  endproperty
  a_tmo: assert property (p_tmo) else $error("watchdog abort missing");

  property p_wr_order;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (strb_on && $fell(dstb_n_reg & astb_n_reg) && !ind_n_reg) |-> $past(pboe_reg && !ind_n_reg && !dir_reg);
  endproperty
  a_wr_order: assert property (p_wr_order) else $error("write strobe before bus");

  property p_rd_order;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (strb_on && $fell(dstb_n_reg & astb_n_reg) && ind_n_reg) |-> $past(!pboe_reg && dir_reg);
  endproperty
  a_rd_order: assert property (p_rd_order) else $error("read strobe before release");

  property p_release;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (strb_on && hold_s_reg && !tmo) |=> dstb_n_reg && astb_n_reg ##1 s_ready_tar;
  endproperty
  a_release: assert property (p_release) else $error("strobe not released");

  property p_wait;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (wd_run && !tmo && !(strb_on && hold_s_reg)) |=> sync_vld_reg && (sync_reg == SYNC_LWAIT);
  endproperty
  a_wait: assert property (p_wait) else $error("wait sync missing");

  property p_pre_hold;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (st_reg == S_PRE && hold_s_reg && !tmo) |=> (st_reg == S_PRE) && $stable(ind_n_reg);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("strobed before hold low");

  property p_wr_hold;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (strb_on && pboe_reg) |-> (pbo_reg == cur_reg.data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write byte not held");

  property p_rd_data;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (st_reg == S_TERM) |=> (rdata_reg == $past(bus_s_reg)) && (sync_reg == SYNC_READY);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read byte lost");

  // captured byte stays in its port register for the rest of the read
  property p_rd_keep;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (st_reg == S_TERM && !eff_wr) |=> (port_reg[cur_idx] == rdata_reg);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read byte not kept");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (tmo && tmo_clr) |=> tmo_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("timeout lost to clear");

  property p_idle_dir;
    @(posedge sys_clk) disable iff (!nrst || !ce)
    (st_reg == S_IDLE && !fifo_vld) |=> (dir_reg == $past(port_direction_ctrl));
  endproperty
  a_idle_dir: assert property (p_idle_dir) else $error("idle direction wrong");
endmodule : ppe_engine

// >>> core/ppe_pkg.sv
// Purpose: shared constants and types for the parallel port engine
// Assumes: 200 MHz sys_clk, host requests on the io_* port
// Notes: offsets are the printed base offsets of the engine registers
package ppe_pkg;
  // ----------------------------------------
  // register offsets from the port base
  // ----------------------------------------
  localparam logic [2:0] OFS_ADDR = 3'h3;
  localparam logic [2:0] OFS_DATA0 = 3'h4;
  localparam int NUM_PORT_REGS = 5;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] ABORT_DATA = 8'hFF;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TMO_US = 10;
  // longest time, rounded down
  localparam logic [10:0] TMO_CYC = 11'(TMO_US * 1000 / CLK_PERIOD_NS);

  // ----------------------------------------
  // host sync codes
  // ----------------------------------------
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_LWAIT = 4'h6;
  localparam logic [3:0] SYNC_TAR = 4'hF;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PM_STD = 2'b00,
    PM_V19 = 2'b01,
    PM_V17 = 2'b10
  } ppe_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PRE = 3'b001,
    S_SETUP = 3'b010,
    S_STRB = 3'b011,
    S_TERM = 3'b100,
    S_SYNC = 3'b101,
    S_TAR = 3'b110
  } ppe_state_t;

  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [7:0] data;
  } ppe_req_t;
endpackage : ppe_pkg

// >>> test/ppe_periph_model.sv
// Purpose: behavioural peripheral on the far side of the engine pins
// Assumes: idle strobes are inactive while traffic runs
// Notes: a released bus shows a toggling pattern, never stale data
`timescale 1ns/1ps
module ppe_periph_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // bench knobs
  input wire logic [7:0] delay,
  input wire logic stall,
  input wire logic hold_hi,
  input wire logic [7:0] rd_byte,
  // pins from the engine
  input wire logic [7:0] port_bus_out,
  input wire logic port_bus_oe,
  input wire logic data_cycle_strobe_n,
  input wire logic addr_cycle_strobe_n,
  input wire logic xfer_out_ind_n,
  // pins to the engine
  output logic [7:0] port_bus_in,
  output logic peripheral_hold_n,
  // observations
  output logic [7:0] wr_byte,
  output logic [7:0] wr_cnt,
  output logic [7:0] strb_cnt,
  output logic was_addr,
  output logic ind_at_strb
);
  // ----------------------------------------
  // strobe tracking
  // ----------------------------------------
  logic strb; // either strobe active
  logic strb_d; // strobe one cycle back
  logic drv; // model owns the bus
  logic [7:0] cnt; // cycles since strobe
  logic [7:0] last; // last bus level
  assign strb = !(data_cycle_strobe_n && addr_cycle_strobe_n);
  // no pull resistor: released bus shows the inverse of its last level
  assign port_bus_in = port_bus_oe ? port_bus_out : (drv ? rd_byte : ~last);

  // hold rises after the setup delay, idles at the hold_hi level between strobes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strb_d <= 1'b0;
      drv <= 1'b0;
      cnt <= 8'h00;
      last <= 8'h00;
      peripheral_hold_n <= 1'b0;
      wr_byte <= 8'h00;
      wr_cnt <= 8'h00;
      strb_cnt <= 8'h00;
      was_addr <= 1'b0;
      ind_at_strb <= 1'b1;
    end
    else
    begin
      strb_d <= strb;
      last <= port_bus_in;
      cnt <= strb ? cnt + 8'h01 : 8'h00;
      // data driven a cycle into the strobe, before hold rises, released a cycle after it
      drv <= strb && !port_bus_oe;
      peripheral_hold_n <= strb ? (!stall && (cnt >= delay)) : hold_hi;
      // new strobe: note its kind and the indication
      if (strb && !strb_d)
      begin
        strb_cnt <= strb_cnt + 8'h01;
        was_addr <= !addr_cycle_strobe_n;
        ind_at_strb <= xfer_out_ind_n;
      end
      // latch the written byte while strobed
      if (strb && !xfer_out_ind_n)
        wr_byte <= port_bus_out;
      if (!strb && strb_d && !xfer_out_ind_n)
        wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule : ppe_periph_model

// >>> test/ppe_engine_bench.sv
// Purpose: self-checking bench for the parallel port engine
// Assumes: control strobe bits low during enhanced traffic
// Notes: watchdog cases run the full count, about 2000 cycles each
`timescale 1ns/1ps
module ppe_engine_bench
  import ppe_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  ppe_mode_t port_mode = PM_V19;
  logic tmo_clr_mode = 1'b0;
  logic ctrl_strobe = 1'b0;
  logic ctrl_autofeed = 1'b0;
  logic ctrl_init = 1'b0;
  logic ctrl_select = 1'b0;
  logic port_direction_ctrl = 1'b0;
  logic [7:0] std_data = 8'h00;
  logic status_rd_done = 1'b0;
  logic status_wr_one = 1'b0;
  logic io_valid = 1'b0;
  logic io_write = 1'b0;
  logic [2:0] io_addr = 3'h0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] delay = 8'h03; // model setup delay
  logic stall = 1'b0; // model never answers
  logic hold_hi = 1'b0; // model hold level between strobes
  logic [7:0] rd_byte = 8'h00;
  logic timeout_flag, io_ready, lpc_sync_vld, port_bus_oe, peripheral_hold_n;
  logic data_cycle_strobe_n, addr_cycle_strobe_n, xfer_out_ind_n, bus_dir_out, init_out;
  logic [3:0] lpc_sync;
  logic [7:0] lpc_rdata, port_bus_in, port_bus_out, wr_byte, wr_cnt, strb_cnt;
  logic was_addr, ind_at_strb, saw_wait, mapped;
  logic [7:0] last_rd, s0, w0;
  int fail_count = 0;
  int checked = 0;
  int done_cnt = 0;
  int cyc = 0;
  int n0, acc;

  // ordinary cases: mode, write, offset, byte written or returned
  typedef struct packed {ppe_mode_t m; logic w; logic [2:0] a; logic [7:0] d;} ppe_row_t;
  localparam int NROW = 12;
  ppe_row_t rows [NROW] = '{
    '{PM_V19, 1'b1, 3'h3, 8'hA5}, '{PM_V19, 1'b0, 3'h3, 8'h3C}, '{PM_V19, 1'b1, 3'h4, 8'h5A},
    '{PM_V19, 1'b0, 3'h5, 8'hC3}, '{PM_V19, 1'b1, 3'h6, 8'h81}, '{PM_V17, 1'b0, 3'h6, 8'h7E},
    '{PM_V17, 1'b1, 3'h7, 8'h18}, '{PM_V17, 1'b0, 3'h7, 8'hE7}, '{PM_V17, 1'b1, 3'h5, 8'h24},
    '{PM_V19, 1'b0, 3'h1, 8'h66}, '{PM_STD, 1'b0, 3'h4, 8'h99}, '{PM_STD, 1'b1, 3'h3, 8'h42}};

  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  ppe_engine #(.FIFO_DEPTH(16)) i_ppe_engine (.sys_clk, .nrst, .ce, .port_mode, .tmo_clr_mode,
    .ctrl_strobe, .ctrl_autofeed, .ctrl_init, .ctrl_select, .port_direction_ctrl, .std_data,
    .status_rd_done, .status_wr_one, .timeout_flag, .io_valid, .io_write, .io_addr, .io_wdata,
    .io_ready, .lpc_sync, .lpc_sync_vld, .lpc_rdata, .port_bus_in, .port_bus_out, .port_bus_oe,
    .peripheral_hold_n, .data_cycle_strobe_n, .addr_cycle_strobe_n, .xfer_out_ind_n,
    .bus_dir_out, .init_out);
  ppe_periph_model i_ppe_periph_model (.sys_clk, .nrst, .delay, .stall, .hold_hi, .rd_byte, .port_bus_out,
    .port_bus_oe, .data_cycle_strobe_n, .addr_cycle_strobe_n, .xfer_out_ind_n, .port_bus_in,
    .peripheral_hold_n, .wr_byte, .wr_cnt, .strb_cnt, .was_addr, .ind_at_strb);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // one host request, held until taken, then wait for its ready sync
  task automatic xact(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = done_cnt;
    saw_wait = 1'b0;
    @(negedge sys_clk);
    io_valid = 1'b1;
    io_write = w;
    io_addr = a;
    io_wdata = d;
    while (io_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    io_valid = 1'b0;
    for (int i = 0; i < 3000 && done_cnt == n; i++) @(negedge sys_clk);
    chk("done", done_cnt - n, 1);
    repeat (3) @(negedge sys_clk);
  endtask : xact

  // status event pulse: write of one or trailing read edge
  task automatic pulse(input logic wr);
    @(negedge sys_clk);
    if (wr) status_wr_one = 1'b1;
    else status_rd_done = 1'b1;
    @(negedge sys_clk);
    status_wr_one = 1'b0;
    status_rd_done = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : pulse

  // sync monitor and hang limit
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (lpc_sync_vld === 1'b1 && lpc_sync === SYNC_LWAIT) saw_wait <= 1'b1;
    if (lpc_sync_vld === 1'b1 && lpc_sync === SYNC_READY)
    begin
      done_cnt <= done_cnt + 1;
      last_rd <= lpc_rdata;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (19) @(negedge sys_clk);
    chk("reset", {data_cycle_strobe_n, addr_cycle_strobe_n, xfer_out_ind_n, port_bus_oe, lpc_sync,
      lpc_sync_vld, timeout_flag, io_ready}, 11'h779);
    @(negedge sys_clk);
    nrst = 1'b1;
    // idle pins follow the control bits
    {ctrl_select, ctrl_autofeed, ctrl_init, ctrl_strobe, port_direction_ctrl} = 5'h1F;
    std_data = 8'h96;
    repeat (3) @(negedge sys_clk);
    chk("idle_in", {addr_cycle_strobe_n, data_cycle_strobe_n, xfer_out_ind_n, init_out, bus_dir_out,
      port_bus_oe}, 6'h06);
    port_direction_ctrl = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("idle_out", {bus_dir_out, port_bus_oe, port_bus_out}, 10'h196);
    {ctrl_select, ctrl_autofeed, ctrl_init, ctrl_strobe} = 4'h0;
    repeat (3) @(negedge sys_clk);
    // table of ordinary transfers
    for (int r = 0; r < NROW; r++)
    begin
      port_mode = rows[r].m;
      rd_byte = rows[r].d;
      s0 = strb_cnt;
      xact(rows[r].w, rows[r].a, rows[r].d);
      mapped = rows[r].m != PM_STD && rows[r].a >= OFS_ADDR;
      if (mapped)
      begin
        chk("strobe", strb_cnt, s0 + 8'h01);
        chk("addr_kind", was_addr, rows[r].a == OFS_ADDR);
        chk("wait_sync", saw_wait, 1'b1);
        if (rows[r].w) chk("wr_byte", wr_byte, rows[r].d);
        else chk("rd_byte", last_rd, rows[r].d);
      end
      else
      begin
        chk("no_strobe", strb_cnt, s0);
        chk("unmapped", last_rd, UNMAPPED_DATA);
      end
    end
    // write with direction bit set runs as a read
    port_mode = PM_V17;
    port_direction_ctrl = 1'b1;
    w0 = wr_cnt;
    xact(1'b1, OFS_DATA0, 8'h99);
    chk("dir_in_write", {wr_cnt == w0, ind_at_strb, timeout_flag}, 3'h6);
    port_direction_ctrl = 1'b0;
    ctrl_strobe = 1'b1;
    xact(1'b0, OFS_DATA0, 8'h00);
    chk("forced_ind", ind_at_strb, 1'b0);
    ctrl_strobe = 1'b0;
    // v1.9 with hold high at start: no strobe until hold drops
    port_mode = PM_V19;
    hold_hi = 1'b1;
    s0 = strb_cnt;
    fork
      xact(1'b1, OFS_DATA0, 8'h3A);
      begin
        repeat (30) @(negedge sys_clk);
        chk("pre_wait", {strb_cnt == s0, saw_wait}, 2'h3);
        hold_hi = 1'b0;
      end
    join
    chk("pre_done", {strb_cnt == s0 + 8'h01, wr_byte == 8'h3A}, 2'h3);
    // watchdog in both variants, both clear modes
    stall = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      port_mode = k[0] ? PM_V17 : PM_V19;
      tmo_clr_mode = k[0];
      xact(1'b0, OFS_DATA0, 8'h00);
      chk("abort_data", last_rd, ABORT_DATA);
      chk("tmo_set", timeout_flag, 1'b1);
      pulse(!k[0]);
      chk("tmo_hold", timeout_flag, 1'b1);
      pulse(k[0]);
      chk("tmo_clr", timeout_flag, 1'b0);
    end
    stall = 1'b0;
    // fill the queue against a slow peripheral, then drain it
    delay = 8'h28;
    n0 = done_cnt;
    @(negedge sys_clk);
    io_valid = 1'b1;
    io_write = 1'b1;
    io_addr = OFS_DATA0;
    for (acc = 0; acc < 40 && io_ready === 1'b1; acc++)
    begin
      io_wdata = 8'(acc);
      @(negedge sys_clk);
    end
    io_valid = 1'b0;
    chk("fill", acc >= 16 && acc <= 17, 1'b1);
    for (int i = 0; i < 3000 && done_cnt - n0 < acc; i++) @(negedge sys_clk);
    chk("drain", done_cnt - n0, acc);
    chk("last_wr", wr_byte, 8'(acc - 1));
    // clock enable low freezes every flop, pins included
    ce = 1'b0;
    ctrl_init = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("ce_freeze", init_out, 1'b0);
    ce = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("ce_run", init_out, 1'b1);
    print_verdict();
  end
endmodule : ppe_engine_bench
